// [hdl/msp_speed_profile.sv]
`timescale 1ns/100ps
`default_nettype none
`include "msp_regs.svh"
module msp_speed_profile #(
  parameter int          CLK_NS    = 20,
  parameter int          TENTH_CYC = `MSP_TENTH_NS / CLK_NS,
  parameter int          LOCK_CYC  = `MSP_LOCK_SHOW_NS / CLK_NS,
  parameter logic [7:0]  WARN_LVL  = 8'hC0,
  parameter logic [7:0]  ALARM_LVL = 8'hF0,
  parameter logic [7:0]  HOLD_GAIN = 8'h04
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire msp_pkg::msp_pins_s  pins_i,
  input  wire msp_pkg::msp_fault_s faults_i,
  input  wire logic [7:0]          pot_time_i,
  input  wire logic [7:0]          stress_i,
  input  wire logic signed [15:0]  angle_dev_i,
  output logic      [11:0]         speed_cmd_o,
  output logic                     drive_en_o,
  output logic                     hold_en_o,
  output logic      [7:0]          hold_torque_o,
  output logic                     lock_ind_o,
  output logic                     warn_o,
  output logic                     alarm_o,
  output msp_pkg::msp_alarm_e      alarm_code_o,
  output logic                     irq_o
);
  import msp_pkg::*;

  localparam int SYNC_W = 16;

  logic [SYNC_W-1:0] sync1;
  logic [SYNC_W-1:0] sync2;
  msp_pins_s         pins;
  msp_fault_s        flt;
  logic [7:0]        pot;
  msp_set_s          sets [4];
  logic [1:0]        ctrl;
  logic [11:0]       lim_lo;
  logic [11:0]       lim_hi;
  logic              lock;
  logic [3:0]        irq_stat;
  logic [3:0]        irq_mask;
  logic [31:0]       lock_cnt;
  msp_state_e        state;
  logic              released;
  logic [39:0]       frac;
  logic              hard_alarm;
  logic              soft_alarm;
  msp_alarm_e        hard_code;
  msp_alarm_e        soft_code;

  // Pins, faults and the time setting pass two flip-flops; stress and angle deviation are read directly.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1 <= 16'h0000;
      sync2 <= 16'h0000;
    end else begin
      sync1 <= {pins_i, faults_i, pot_time_i};
      sync2 <= sync1;
    end
  end
  // The synchronised bundle is split back into pins, faults and the time setting.
  assign pins = sync2[15:12];
  assign flt  = sync2[11:8];
  assign pot  = sync2[7:0];

  // Bus slave: one wait state, write takes effect at the edge where ack is high.
  logic        wr;
  logic [31:0] wmask;
  logic        cfg_wr;
  logic        lock_evt;
  logic        refuse_evt;
  logic [31:0] wval;
  assign wr     = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign cfg_wr = wr && (wb_adr_i == `MSP_OFF_CTRL || wb_adr_i == `MSP_OFF_LIMITS ||
                         wb_adr_i == `MSP_OFF_INIT || wb_adr_i[7:5] == 3'b001);
  assign lock_evt = cfg_wr && lock;

  function automatic logic [31:0] merge(input logic [31:0] old);
    merge = (old & ~wmask) | (wb_dat_i & wmask);
  endfunction : merge

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      // Ack lasts one cycle; a master that still holds its request is answered again every second cycle.
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      wb_dat_o <= 32'h0000_0000;
      case (wb_adr_i)
        // Read data is latched in the request cycle and stands together with ack.
        `MSP_OFF_CTRL:     wb_dat_o <= {30'h0000_0000, ctrl};
        `MSP_OFF_LIMITS:   wb_dat_o <= {4'h0, lim_hi, 4'h0, lim_lo};
        `MSP_OFF_LOCK:     wb_dat_o <= {31'h0000_0000, lock};
        `MSP_OFF_STATUS:   wb_dat_o <= {8'h00, lock_ind_o, warn_o, alarm_o, alarm_code_o,
                                        state, speed_cmd_o, pins.sel, pins.stop, pins.run};
        `MSP_OFF_IRQ_STAT: wb_dat_o <= {28'h000_0000, irq_stat};
        `MSP_OFF_IRQ_MASK: wb_dat_o <= {28'h000_0000, irq_mask};
        `MSP_OFF_ALARM:    wb_dat_o <= {29'h0000_0000, alarm_code_o};
        default: begin
          if (wb_adr_i[7:4] == 4'h2 && wb_adr_i[1:0] == 2'b00) begin
            wb_dat_o <= {20'h0_0000, sets[wb_adr_i[3:2]].speed};
          end else if (wb_adr_i[7:4] == 4'h3 && wb_adr_i[1:0] == 2'b00) begin
            wb_dat_o <= {8'h00, sets[wb_adr_i[3:2]].dec, 8'h00, sets[wb_adr_i[3:2]].acc};
          end
        end
      endcase
    end
  end

  function automatic logic [1:0] wval_ctrl();
    logic [31:0] v;
    v = merge({30'h0000_0000, ctrl});
    wval_ctrl = v[1:0];
  endfunction : wval_ctrl

  // Control and limit registers; the lock register itself stays writable.
  // A limit pair that leaves the range or crosses over is dropped whole.
  logic        lim_ok;
  assign wval   = merge({4'h0, lim_hi, 4'h0, lim_lo});
  assign lim_ok = wval[11:0] >= `MSP_SPEED_MIN && wval[27:16] <= `MSP_SPEED_MAX &&
                  wval[11:0] <= wval[27:16];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl   <= 2'h0;
      lim_lo <= `MSP_SPEED_MIN;
      lim_hi <= `MSP_SPEED_MAX;
    end else if (wr && !lock) begin
      if (wb_adr_i == `MSP_OFF_CTRL) begin
        ctrl <= wval_ctrl();
      end
      if (wb_adr_i == `MSP_OFF_LIMITS && lim_ok) begin
        lim_lo <= wval[11:0];
        lim_hi <= wval[27:16];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock <= 1'b0;
    end else if (wr && wb_adr_i == `MSP_OFF_LOCK && wb_sel_i[0]) begin
      lock <= wb_dat_i[0];
    end
  end

  // Four data sets; stored speeds follow limit changes.
  logic [3:0] refuse_set;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_set
      logic        sp_wr;
      logic        tm_wr;
      logic        init;
      logic [31:0] sv;
      logic [31:0] tv;
      assign sp_wr = wr && !lock && wb_adr_i == (`MSP_OFF_SPEED0 + 8'(4 * g));
      assign tm_wr = wr && !lock && wb_adr_i == (`MSP_OFF_TIME0 + 8'(4 * g));
      assign init  = wr && !lock && wb_adr_i == `MSP_OFF_INIT && wb_sel_i[0] && wb_dat_i[g];
      assign sv    = merge({20'h0_0000, sets[g].speed});
      assign tv    = merge({8'h00, sets[g].dec, 8'h00, sets[g].acc});
      assign refuse_set[g] = (sp_wr && (sv[11:0] > lim_hi || sv[11:0] < lim_lo)) ||
                             (tm_wr && (tv[7:0] < `MSP_TIME_MIN || tv[7:0] > `MSP_TIME_MAX ||
                                        tv[23:16] < `MSP_TIME_MIN || tv[23:16] > `MSP_TIME_MAX));
      // A write inside the limits wins over clamping; clamping compares against the
      // registered limits, so it follows a limit change one cycle later.
      always_ff @(posedge clk_i) begin
        if (rst_i || init) begin
          sets[g] <= '{speed: `MSP_SPEED_MIN, acc: `MSP_DIG_DEFAULT, dec: `MSP_DIG_DEFAULT};
        end else if (sp_wr && !refuse_set[g]) begin
          sets[g].speed <= sv[11:0];
        end else if (tm_wr && !refuse_set[g]) begin
          sets[g].acc <= tv[7:0];
          sets[g].dec <= tv[23:16];
        end else if (sets[g].speed > lim_hi) begin
          sets[g].speed <= lim_hi;
        end else if (sets[g].speed < lim_lo) begin
          sets[g].speed <= lim_lo;
        end
      end
    end
  endgenerate
  assign refuse_evt = |refuse_set;

  // Lock indication stands for one second after a rejected change.
  // Every rejected change reloads the counter, so repeated attempts stretch the indication.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_cnt   <= 32'h0000_0000;
      lock_ind_o <= 1'b0;
    end else if (lock_evt) begin
      lock_cnt   <= 32'(LOCK_CYC - 1);
      lock_ind_o <= 1'b1;
    end else if (lock_cnt != 32'h0000_0000) begin
      lock_cnt <= lock_cnt - 32'h0000_0001;
    end else begin
      lock_ind_o <= 1'b0;
    end
  end

  // Alarms: hard ones survive alarm reset and clear only by reset.
  // The first cause of each kind is latched; a later hard fault replaces a soft code, nothing else overwrites it.
  logic alarm_clr;
  logic warn_now;
  assign alarm_clr = wr && wb_adr_i == `MSP_OFF_ALARM && wb_sel_i[0] && wb_dat_i[0];
  assign warn_now  = stress_i >= WARN_LVL;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hard_alarm <= 1'b0;
      hard_code  <= AL_NONE;
    end else if (!hard_alarm && (flt.overcurrent || flt.nv_error)) begin
      hard_alarm <= 1'b1;
      hard_code  <= flt.overcurrent ? AL_OVERCURRENT : AL_NV_ERROR;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      soft_alarm <= 1'b0;
      soft_code  <= AL_NONE;
    end else if (!soft_alarm && (flt.sensor || flt.overheat || stress_i >= ALARM_LVL)) begin
      soft_alarm <= 1'b1;
      soft_code  <= flt.sensor ? AL_SENSOR : flt.overheat ? AL_OVERHEAT : AL_OVERLOAD;
    end else if (alarm_clr) begin
      soft_alarm <= 1'b0;
      soft_code  <= AL_NONE;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_o      <= 1'b0;
      alarm_code_o <= AL_NONE;
      warn_o       <= 1'b0;
    end else begin
      alarm_o      <= hard_alarm || soft_alarm;
      alarm_code_o <= hard_alarm ? hard_code : soft_code;
      // The warning is masked while an alarm stands, so the alarm code alone explains the stop.
      warn_o       <= warn_now && !(hard_alarm || soft_alarm);
    end
  end

  // Run state machine.
  // External stop wins over run, so a held stop pin keeps the command at zero.
  // Holding is released after a stop or an alarm and returns only with the next run.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= ST_IDLE;
      released <= 1'b0;
    end else begin
      case (state)
        ST_IDLE, ST_RUN: begin
          if (hard_alarm || soft_alarm) begin
            state    <= ST_ALARM;
            released <= 1'b1;
          end else if (pins.stop) begin
            state <= ST_ESTOP;
          end else if (pins.run) begin
            state    <= ST_RUN;
            released <= 1'b0;
          end else begin
            state <= ST_IDLE;
          end
        end
        ST_ESTOP: begin
          state    <= ST_IDLE;
          released <= 1'b1;
        end
        ST_ALARM: begin
          if (!(hard_alarm || soft_alarm)) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Linear ramp: one r/min step whenever the fraction passes the time in cycles.
  // The fraction keeps the remainder, so the mean slope is exact while the time in cycles is not below the reference speed.
  // A stop or an alarm zeroes the command at once instead of ramping down.
  msp_set_s    act;
  logic [11:0] target;
  logic        up;
  logic [11:0] ref_spd;
  logic [7:0]  tsel;
  logic [7:0]  tpot;
  logic [39:0] tcyc;
  logic [39:0] next_frac;
  assign act    = sets[pins.sel];
  assign target = (state == ST_RUN) ? act.speed : 12'h000;
  assign up     = target > speed_cmd_o;
  assign tpot   = pot < `MSP_TIME_MIN ? `MSP_POT_DEFAULT : pot > `MSP_TIME_MAX ? `MSP_TIME_MAX : pot;
  assign ref_spd = ctrl[`MSP_CTRL_DIGITAL] ? act.speed : `MSP_SPEED_RATED;
  assign tsel   = ctrl[`MSP_CTRL_DIGITAL] ? (up ? act.acc : act.dec) : tpot;
  assign tcyc   = 40'(tsel) * 40'(TENTH_CYC);
  assign next_frac = frac + 40'(ref_spd);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      speed_cmd_o <= 12'h000;
      frac        <= 40'h00_0000_0000;
    end else if (state == ST_ESTOP || state == ST_ALARM) begin
      speed_cmd_o <= 12'h000;
      frac        <= 40'h00_0000_0000;
    end else if (target == speed_cmd_o) begin
      frac <= 40'h00_0000_0000;
    end else if (next_frac >= tcyc) begin
      frac        <= next_frac - tcyc;
      speed_cmd_o <= up ? speed_cmd_o + 12'h001 : speed_cmd_o - 12'h001;
    end else begin
      frac <= next_frac;
    end
  end

  // Drive and standstill holding.
  // Torque is forced to zero whenever holding is off, so a stale deviation never reaches the stage.
  logic [15:0] dev_abs;
  logic [23:0] trq;
  logic        next_hold;
  logic [7:0]  next_torque;
  assign dev_abs = angle_dev_i[15] ? 16'(-angle_dev_i) : angle_dev_i;
  assign trq     = 24'(dev_abs) * 24'(HOLD_GAIN);
  // The product is scaled down by 256 and capped at half of rated torque.
  assign next_torque = trq[23:8] > 16'(`MSP_HOLD_MAX) ? `MSP_HOLD_MAX : trq[15:8];
  assign next_hold   = ctrl[`MSP_CTRL_HOLD] && !released && state == ST_IDLE &&
                       speed_cmd_o == 12'h000;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      drive_en_o    <= 1'b0;
      hold_en_o     <= 1'b0;
      hold_torque_o <= 8'h00;
    end else begin
      drive_en_o <= state == ST_RUN || (state == ST_IDLE && speed_cmd_o != 12'h000);
      hold_en_o     <= next_hold;
      hold_torque_o <= next_hold ? next_torque : 8'h00;
    end
  end

  // Sticky events: lock reject, refused write, alarm, warning. Set wins over clear.
  // Alarm and warning are levels, so their bits return while the cause stands.
  logic [3:0] ev;
  assign ev = {warn_now, hard_alarm || soft_alarm, refuse_evt, lock_evt};
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= 4'h0;
      irq_mask <= 4'h0;
      irq_o    <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~((wr && wb_adr_i == `MSP_OFF_IRQ_STAT && wb_sel_i[0]) ?
                               wb_dat_i[3:0] : 4'h0)) | ev;
      if (wr && wb_adr_i == `MSP_OFF_IRQ_MASK && wb_sel_i[0]) begin
        irq_mask <= wb_dat_i[3:0];
      end
      irq_o <= |(irq_stat & irq_mask);
    end
  end
endmodule : msp_speed_profile
`default_nettype wire

// [hdl/msp_regs.svh]
// What this block does
// - Four operation data sets; two select pins pick the active one.
// - Set speed range 50 to 4000 r/min, each set defaults to 50.
// - Ramp time comes from the potentiometer by default, 0.1 to 15.0 s.
// - Potentiometer acceleration time means standstill to 3000 r/min.
// - Potentiometer deceleration time means 3000 r/min to standstill.
// - Digital source uses per-set times, meaning time to reach the set speed.
// - Digital times accept 0.1 to 15.0 s, default 0.5 s.
// - Edit lock rejects every change to data and configuration.
// - A change attempted under lock shows the lock indication for one second.
// - Speeds above the upper limit are refused; stored ones are clamped down.
// - Speeds below the lower limit are refused; stored ones are clamped up.
// - Optional standstill holding torque follows shaft deviation, at most 50 %.
// - Initialising a data set restores its default values.
// - A protective alarm removes drive, releases holding, shows the alarm code.
// - A warning is raised before the matching alarm level is reached.
// - Overcurrent and storage error alarms clear only by power cycle (reset).
// - External stop halts the motor at once, then releases holding.
`ifndef MSP_REGS_SVH
`define MSP_REGS_SVH
`define MSP_OFF_CTRL     8'h00
`define MSP_OFF_LIMITS   8'h04
`define MSP_OFF_LOCK     8'h08
`define MSP_OFF_STATUS   8'h0C
`define MSP_OFF_IRQ_STAT 8'h10
`define MSP_OFF_IRQ_MASK 8'h14
`define MSP_OFF_ALARM    8'h18
`define MSP_OFF_INIT     8'h1C
`define MSP_OFF_SPEED0   8'h20
`define MSP_OFF_TIME0    8'h30
`define MSP_CTRL_DIGITAL 0
`define MSP_CTRL_HOLD    1
`define MSP_SPEED_MIN    12'h0032
`define MSP_SPEED_MAX    12'h0FA0
`define MSP_SPEED_RATED  12'h0BB8
`define MSP_TIME_MIN     8'h01
`define MSP_TIME_MAX     8'h96
`define MSP_POT_DEFAULT  8'h01
`define MSP_DIG_DEFAULT  8'h05
`define MSP_HOLD_MAX     8'h32
`define MSP_TENTH_NS     100000000
`define MSP_LOCK_SHOW_NS 1000000000
`endif

// [hdl/msp_pkg.sv]
package msp_pkg;
  typedef struct packed {
    logic       run;
    logic       stop;
    logic [1:0] sel;
  } msp_pins_s;
  typedef struct packed {
    logic overcurrent;
    logic nv_error;
    logic sensor;
    logic overheat;
  } msp_fault_s;
  typedef struct packed {
    logic [11:0] speed;
    logic [7:0]  acc;
    logic [7:0]  dec;
  } msp_set_s;
  typedef enum logic [2:0] {AL_NONE, AL_OVERCURRENT, AL_NV_ERROR, AL_SENSOR, AL_OVERHEAT,
                            AL_OVERLOAD} msp_alarm_e;
  typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_ESTOP, ST_ALARM} msp_state_e;
endpackage : msp_pkg

// [tb/msp_speed_profile_chk.sv]
`timescale 1ns/100ps
`default_nettype none
`include "msp_regs.svh"
module msp_speed_profile_chk #(
  parameter logic [7:0] WARN_LVL = 8'hC0
) (
  input wire logic                clk_i,
  input wire logic                rst_i,
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_ack_o,
  input wire msp_pkg::msp_pins_s  pins_i,
  input wire logic [7:0]          stress_i,
  input wire logic [11:0]         speed_cmd_o,
  input wire logic                drive_en_o,
  input wire logic                hold_en_o,
  input wire logic [7:0]          hold_torque_o,
  input wire logic                lock_ind_o,
  input wire logic                warn_o,
  input wire logic                alarm_o,
  input wire msp_pkg::msp_alarm_e alarm_code_o
);
  import msp_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  AST_ACK_LATENCY: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("Bus request not answered after one cycle.");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Bus answer held longer than one cycle.");
  AST_RAMP_STEP: assert property ($changed(speed_cmd_o) && speed_cmd_o != 12'h000 |->
    speed_cmd_o == $past(speed_cmd_o) + 12'h001 || speed_cmd_o + 12'h001 == $past(speed_cmd_o))
    else $error("Speed command moved by more than one step.");
  AST_SPEED_CEIL: assert property (speed_cmd_o <= `MSP_SPEED_MAX)
    else $error("Speed command above the top of the range.");
  AST_ALARM_COAST: assert property (alarm_o [*2] |->
    !drive_en_o && !hold_en_o && speed_cmd_o == 12'h000 && alarm_code_o != AL_NONE)
    else $error("Drive or holding kept during an alarm.");
  AST_HOLD_CAP: assert property (hold_torque_o <= `MSP_HOLD_MAX)
    else $error("Holding torque above half of rated torque.");
  AST_HOLD_ONLY_HELD: assert property (hold_torque_o != 8'h00 |-> hold_en_o || $past(hold_en_o))
    else $error("Holding torque without holding enabled.");
  AST_LOCK_SHOW: assert property ($rose(lock_ind_o) |=> lock_ind_o [*8])
    else $error("Lock indication dropped too early.");
  AST_ESTOP_ZERO: assert property (pins_i.stop [*6] |-> speed_cmd_o == 12'h000 && !hold_en_o)
    else $error("External stop did not halt and release the shaft.");
  AST_WARN_FIRST: assert property (stress_i >= WARN_LVL |=> warn_o || alarm_o)
    else $error("Warning not raised at the warning level.");
endmodule : msp_speed_profile_chk
bind msp_speed_profile msp_speed_profile_chk #(.WARN_LVL(WARN_LVL)) u_msp_speed_profile_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .pins_i(pins_i), .stress_i(stress_i), .speed_cmd_o(speed_cmd_o), .drive_en_o(drive_en_o),
  .hold_en_o(hold_en_o), .hold_torque_o(hold_torque_o), .lock_ind_o(lock_ind_o), .warn_o(warn_o),
  .alarm_o(alarm_o), .alarm_code_o(alarm_code_o));
`default_nettype wire

// [tb/msp_ctrl_model.sv]
`timescale 1ns/100ps
`default_nettype none
// Outside controller: it changes its pins just after an edge, then lets them settle.
module msp_ctrl_model (
  input  wire logic             clk_i,
  output var msp_pkg::msp_pins_s pins_o
);
  import msp_pkg::*;
  initial pins_o = '0;
  task automatic drive(input logic run, input logic stop, input logic [1:0] sel, input int settle);
    @(posedge clk_i);
    pins_o <= '{run: run, stop: stop, sel: sel};
    repeat (settle) @(posedge clk_i);
  endtask : drive
endmodule : msp_ctrl_model
`default_nettype wire

// [tb/msp_speed_profile_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module msp_speed_profile_bench;
  import msp_pkg::*;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               wb_cyc_i = 1'b0;
  logic               wb_stb_i = 1'b0;
  logic               wb_we_i = 1'b0;
  logic [7:0]         wb_adr_i = 8'h00;
  logic [3:0]         wb_sel_i = 4'hF;
  logic [31:0]        wb_dat_i = 32'h0000_0000;
  logic [31:0]        wb_dat_o, rd;
  logic               wb_ack_o, drive_en_o, hold_en_o, lock_ind_o, warn_o, alarm_o, irq_o;
  msp_pins_s          pins;
  msp_fault_s         faults_i = '0;
  logic [7:0]         pot_time_i = 8'h96;
  logic [7:0]         stress_i = 8'h00;
  logic signed [15:0] angle_dev_i = 16'sh0000;
  logic [11:0]        speed_cmd_o;
  logic [7:0]         hold_torque_o;
  msp_alarm_e         alarm_code_o;
  int                 err_count = 0;
  int                 tests_run = 0;
  int                 cycles = 0;

  always #10 clk_i = ~clk_i;

  // Short tenth-second and lock counts: 0.1 s of ramp time is 100 cycles, the lock indication 20 cycles.
  msp_speed_profile #(.TENTH_CYC(100), .LOCK_CYC(20)) u_msp_speed_profile (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pins_i(pins), .faults_i(faults_i), .pot_time_i(pot_time_i), .stress_i(stress_i),
    .angle_dev_i(angle_dev_i), .speed_cmd_o(speed_cmd_o), .drive_en_o(drive_en_o), .hold_en_o(hold_en_o),
    .hold_torque_o(hold_torque_o), .lock_ind_o(lock_ind_o), .warn_o(warn_o), .alarm_o(alarm_o),
    .alarm_code_o(alarm_code_o), .irq_o(irq_o));
  msp_ctrl_model u_msp_ctrl_model (.clk_i(clk_i), .pins_o(pins));

  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
  endtask : step

  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hF;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic rc(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0000_0000);
    chk($sformatf("register %h", adr), exp, rd);
  endtask : rc

  // Ramp timing depends on synchroniser delay, so ramps are judged within a narrow band.
  task automatic rng(input string name, input int lo, input int hi, input logic [11:0] got);
    tests_run++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_count++;
      $display("ERROR %s expected %0d to %0d seen %0d", name, lo, hi, got);
    end
  endtask : rng

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    step(4);
    rst_i <= 1'b0;
    rc(8'h04, 32'h0FA0_0032);
    for (int n = 0; n < 4; n++) begin
      rc(8'h20 + 8'(4 * n), 32'h0000_0032);
      rc(8'h30 + 8'(4 * n), 32'h0005_0005);
    end
    rc(8'h00, 32'h0000_0000);
    wb(1'b1, 8'h20, 32'h0000_0FA1);
    wb(1'b1, 8'h20, 32'h0000_0031);
    wb(1'b1, 8'h30, 32'h0005_0000);
    wb(1'b1, 8'h30, 32'h0097_0005);
    rc(8'h20, 32'h0000_0032);
    rc(8'h30, 32'h0005_0005);
    rc(8'h10, 32'h0000_0002);
    chk("irq_o masked", 1'h0, irq_o);
    wb(1'b1, 8'h14, 32'h0000_0002);
    step(2);
    chk("irq_o", 1'h1, irq_o);
    wb(1'b1, 8'h10, 32'h0000_0002);
    step(2);
    chk("irq_o cleared", 1'h0, irq_o);
    wb(1'b1, 8'h24, 32'h0000_0FA0);
    wb(1'b1, 8'h04, 32'h0BB8_0064);
    step(8);
    rc(8'h20, 32'h0000_0064);
    rc(8'h24, 32'h0000_0BB8);
    wb(1'b1, 8'h28, 32'h0000_0BB9);
    rc(8'h28, 32'h0000_0064);
    wb(1'b1, 8'h04, 32'h0FA0_0032);
    wb(1'b1, 8'h1C, 32'h0000_0002);
    rc(8'h24, 32'h0000_0032);
    wb(1'b1, 8'h08, 32'h0000_0001);
    wb(1'b1, 8'h28, 32'h0000_00C8);
    step(2);
    chk("lock_ind_o", 1'h1, lock_ind_o);
    rc(8'h28, 32'h0000_0064);
    rc(8'h10, 32'h0000_0003);
    step(25);
    chk("lock_ind_o off", 1'h0, lock_ind_o);
    wb(1'b1, 8'h08, 32'h0000_0000);
    wb(1'b1, 8'h10, 32'h0000_0003);
    wb(1'b1, 8'h28, 32'h0000_00C8);
    for (int s = 0; s < 4; s++) begin
      u_msp_ctrl_model.drive(1'b0, 1'b0, 2'(s), 4);
      wb(1'b0, 8'h0C, 32'h0000_0000);
      chk("status select", 32'(s), {30'h0, rd[3:2]});
    end
    chk("hold_en_o default", 1'h0, hold_en_o);
    wb(1'b1, 8'h00, 32'h0000_0002);
    angle_dev_i <= 16'sh03E8;
    step(4);
    chk("hold_en_o", 1'h1, hold_en_o);
    chk("hold_torque_o", 8'h0F, hold_torque_o);
    angle_dev_i <= -16'sh7530;
    step(4);
    chk("hold_torque_o cap", 8'h32, hold_torque_o);
    wb(1'b1, 8'h00, 32'h0000_0000);
    step(2);
    chk("hold_torque_o off", 8'h00, hold_torque_o);
    u_msp_ctrl_model.drive(1'b1, 1'b0, 2'h2, 500);
    rng("pot accel", 95, 100, speed_cmd_o);
    chk("drive_en_o run", 1'h1, drive_en_o);
    step(700);
    chk("speed target", 12'h0C8, speed_cmd_o);
    u_msp_ctrl_model.drive(1'b0, 1'b0, 2'h2, 500);
    rng("pot decel", 99, 106, speed_cmd_o);
    step(700);
    wb(1'b1, 8'h00, 32'h0000_0003);
    wb(1'b1, 8'h38, 32'h0096_0096);
    u_msp_ctrl_model.drive(1'b1, 1'b0, 2'h2, 750);
    rng("digital accel", 8, 10, speed_cmd_o);
    u_msp_ctrl_model.drive(1'b1, 1'b1, 2'h2, 8);
    chk("stop speed", 12'h000, speed_cmd_o);
    chk("stop hold", 1'h0, hold_en_o);
    u_msp_ctrl_model.drive(1'b0, 1'b0, 2'h2, 4);
    stress_i <= 8'hC0;
    step(3);
    chk("warn_o", 1'h1, warn_o);
    chk("alarm_o early", 1'h0, alarm_o);
    stress_i <= 8'hF0;
    step(3);
    chk("alarm_code_o", AL_OVERLOAD, alarm_code_o);
    stress_i <= 8'h00;
    wb(1'b1, 8'h18, 32'h0000_0001);
    step(3);
    chk("alarm_o soft reset", 1'h0, alarm_o);
    faults_i <= '{overcurrent: 1'b1, default: 1'b0};
    step(5);
    faults_i <= '0;
    wb(1'b1, 8'h18, 32'h0000_0001);
    step(3);
    chk("alarm_code_o kept", AL_OVERCURRENT, alarm_code_o);
    chk("drive_en_o", 1'h0, drive_en_o);
    rst_i <= 1'b1;
    step(4);
    rst_i <= 1'b0;
    step(4);
    chk("alarm_o power cycle", 1'h0, alarm_o);
    end_of_test();
  end
endmodule : msp_speed_profile_bench
`default_nettype wire
